// ==== hw/cic_regs.sv ====
// Purpose: I2C-reached input-limit and control-zero registers of a
//          single-cell charger, with their operating decisions.
// Assumes: SCL is never stretched; master keeps SCL well below clk_sys.
// Notes:   Only offsets 0x00 and 0x01 live here; others refuse writes and read as 0xFF.
`include "cic_map.svh"
module cic_regs
	import cic_pkg::*;
(
	// Clock and reset
	input  wire logic        clk_sys,
	input  wire logic        nrst,
	// I2C pins, open drain
	input  wire logic        sclIn,
	input  wire logic        sdaIn,
	output logic             sdaOut,
	output logic             sdaOe,
	// Events from charger core, clk_sys domain
	input  wire logic        regResetCmd,
	input  wire logic        watchdogExpired,
	input  wire logic        detectDone,
	// Device pins, asynchronous
	input  wire logic        sourceSelPin,
	input  wire logic        chargeEnPin_n,
	input  wire logic        adapterPresentPin,
	// Core status, clk_sys domain
	input  wire logic        remoteSenseFaultStatus,
	input  wire logic [2:0]  thermistorFaultIn,
	input  wire logic        thermistorGoodIn,
	input  wire logic        chargeCurrentNonzero,
	// Register fields
	output logic             inputDisconnectMode,
	output logic             lightLoadPulseSkipDisable,
	output logic [4:0]       inputCurrentLimitCode,
	output logic [2:0]       systemFloorVoltageSel,
	// Decisions and values
	output logic [2:0]       thermistorFaultCode,
	output logic             useRemoteSense,
	output logic [11:0]      inputLimitMa,
	output logic [11:0]      systemFloorMv,
	output logic [11:0]      boostExitMv,
	output logic [11:0]      boostStartMv,
	output logic             chargeActive,
	output logic             boostActive,
	output logic             watchdogKick,
	output logic             hostMode
);

	// Synchronised pins
	logic       sclS;          // SCL in clk_sys domain
	logic       sdaS;          // SDA in clk_sys domain
	logic       pselS;         // Source-select pin
	logic       ceNS;          // Charge-enable pin, active low
	logic       adapS;         // Adapter present
	logic       sclD_r;        // SCL one cycle late
	logic       sdaD_r;        // SDA one cycle late
	logic       sclRise;       // SCL rising edge
	logic       sclFall;       // SCL falling edge
	logic       startSeen;     // START or repeated START
	logic       stopSeen;      // STOP

	// Serial engine state
	cic_state_t state_r;       // Slave state
	cic_state_t state_nxt;
	logic [3:0] bitCnt_r;      // Bits clocked; 9 marks the ack slot
	logic [3:0] bitCnt_nxt;
	logic [7:0] shift_r;       // Receive shifter
	logic [7:0] shift_nxt;
	logic [7:0] tx_r;          // Transmit shifter
	logic [7:0] tx_nxt;
	logic [7:0] ptr_r;         // Register pointer
	logic [7:0] ptr_nxt;
	logic       nack_r;        // Master refused last read byte
	logic       nack_nxt;
	logic       sdaOe_r;       // SDA pulled low
	logic       sdaOe_nxt;
	logic       wrStb;         // Write shifter into pointed register
	logic [7:0] rdByte;        // Read value at pointer
	logic       ptrOk;         // Pointer names a register here

	// Register group state
	logic [7:0] inLim_r;       // Input-limit register
	logic [7:0] inLim_nxt;
	logic [7:0] ctrl_r;        // Control-zero register
	logic [7:0] ctrl_nxt;
	logic       host_r;        // Host-controlled mode
	logic       host_nxt;
	logic       kick_r;        // Watchdog restart pulse
	logic       kick_nxt;

	// Output registers for decoded values
	logic [2:0]  ntcCode_r;
	logic        useRem_r;
	logic [11:0] limMa_r;
	logic [11:0] floorMv_r;
	logic [11:0] bExit_r;
	logic [11:0] bRise_r;
	logic        chgOn_r;
	logic        bstOn_r;

	cic_ctl_if ctl ();

	// Pins pass two flops; idle bus lines reset high
	cic_sync #(
		.W    (5),
		.RSTV (5'h03)
	) u_sync (
		.clk_sys (clk_sys),
		.nrst    (nrst),
		.din     ({adapterPresentPin, chargeEnPin_n, sourceSelPin,
		           sclIn, sdaIn}),
		.dout    ({adapS, ceNS, pselS, sclS, sdaS})
	);

	// Decision logic, registered below
	cic_decode u_dec (
		.ctl (ctl.dec)
	);

	// Feed the decoder
	assign ctl.inLimReg    = inLim_r;
	assign ctl.ctrlReg     = ctrl_r;
	assign ctl.senseFault  = remoteSenseFaultStatus;
	assign ctl.ntcRaw      = thermistorFaultIn;
	assign ctl.ntcGoodRaw  = thermistorGoodIn;
	assign ctl.ceLow       = !ceNS;
	assign ctl.adapterOn   = adapS;
	assign ctl.currNonzero = chargeCurrentNonzero;

	// Bus conditions from synchronised lines
	assign sclRise   = sclS && !sclD_r;
	assign sclFall   = !sclS && sclD_r;
	assign startSeen = sclS && sclD_r && sdaD_r && !sdaS;
	assign stopSeen  = sclS && sclD_r && !sdaD_r && sdaS;

	// Only the two local offsets are mapped
	assign ptrOk  = (ptr_r <= `CIC_OFS_CTRL0);

	// Read mux; unmapped offsets read as all ones
	always_comb begin
		if (ptr_r == `CIC_OFS_INLIM) begin
			rdByte = inLim_r;
		end else if (ptr_r == `CIC_OFS_CTRL0) begin
			rdByte = ctrl_r;
		end else begin
			rdByte = `CIC_READ_FILL;
		end
	end

	// Serial slave next state
	always_comb begin
		state_nxt  = state_r;
		bitCnt_nxt = bitCnt_r;
		shift_nxt  = shift_r;
		tx_nxt     = tx_r;
		ptr_nxt    = ptr_r;
		nack_nxt   = nack_r;
		sdaOe_nxt  = sdaOe_r;
		wrStb      = 1'b0;
		if (startSeen) begin
			// Any START restarts address phase
			state_nxt  = ST_ADDR;
			bitCnt_nxt = 4'h0;
			sdaOe_nxt  = 1'b0;
		end else if (stopSeen) begin
			state_nxt = ST_IDLE;
			sdaOe_nxt = 1'b0;
		end else if (state_r != ST_IDLE) begin
			if (sclRise) begin
				if (bitCnt_r < 4'h8) begin
					// Sample MSB first
					shift_nxt  = {shift_r[6:0], sdaS};
					bitCnt_nxt = bitCnt_r + 4'h1;
				end else if (bitCnt_r == 4'h9) begin
					// Master ack on reads
					nack_nxt = sdaS;
				end
			end else if (sclFall) begin
				if (bitCnt_r == 4'h8) begin
					// Byte done: enter ack slot
					bitCnt_nxt = 4'h9;
					sdaOe_nxt  = 1'b0;
					case (state_r)
						ST_ADDR: begin
							if (shift_r[7:1] == `CIC_SLAVE_ADDR) begin
								sdaOe_nxt = 1'b1;
							end else begin
								state_nxt = ST_IDLE;
							end
						end
						ST_REGA: begin
							// Undefined offset is refused with NACK
							if (shift_r <= `CIC_OFS_CTRL0) begin
								sdaOe_nxt = 1'b1;
								ptr_nxt   = shift_r;
							end else begin
								state_nxt = ST_IDLE;
							end
						end
						ST_WDATA: begin
							if (ptrOk) begin
								sdaOe_nxt = 1'b1;
								wrStb     = 1'b1;
								ptr_nxt   = ptr_r + 8'h01;
							end else begin
								state_nxt = ST_IDLE;
							end
						end
						ST_RDATA: begin
							// Release for master ack, step pointer
							ptr_nxt = ptr_r + 8'h01;
						end
						default: begin
							state_nxt = ST_IDLE;
						end
					endcase
				end else if (bitCnt_r == 4'h9) begin
					// Ack slot over
					bitCnt_nxt = 4'h0;
					sdaOe_nxt  = 1'b0;
					case (state_r)
						ST_ADDR: begin
							if (shift_r[0]) begin
								state_nxt = ST_RDATA;
								tx_nxt    = rdByte;
								sdaOe_nxt = !rdByte[7];
							end else begin
								state_nxt = ST_REGA;
							end
						end
						ST_REGA: begin
							state_nxt = ST_WDATA;
						end
						ST_RDATA: begin
							if (nack_r) begin
								state_nxt = ST_IDLE;
							end else begin
								tx_nxt    = rdByte;
								sdaOe_nxt = !rdByte[7];
							end
						end
						default: begin
						end
					endcase
				end else if (state_r == ST_RDATA) begin
					// Present next bit while SCL is low
					tx_nxt    = {tx_r[6:0], 1'b0};
					sdaOe_nxt = !tx_r[6];
				end
			end
		end
	end

	// Serial slave registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_r  <= ST_IDLE;
			bitCnt_r <= 4'h0;
			shift_r  <= 8'h00;
			tx_r     <= 8'h00;
			ptr_r    <= 8'h00;
			nack_r   <= 1'b0;
			sdaOe_r  <= 1'b0;
			sclD_r   <= 1'b1;
			sdaD_r   <= 1'b1;
		end else begin
			state_r  <= state_nxt;
			bitCnt_r <= bitCnt_nxt;
			shift_r  <= shift_nxt;
			tx_r     <= tx_nxt;
			ptr_r    <= ptr_nxt;
			nack_r   <= nack_nxt;
			sdaOe_r  <= sdaOe_nxt;
			sclD_r   <= sclS;
			sdaD_r   <= sdaS;
		end
	end

	// Register group next state; later branches take priority
	always_comb begin
		inLim_nxt = inLim_r;
		ctrl_nxt  = ctrl_r;
		host_nxt  = host_r;
		kick_nxt  = 1'b0;
		// Kick bit restarts the timer, then drops by itself
		if (ctrl_r[`CIC_B_KICK]) begin
			ctrl_nxt[`CIC_B_KICK] = 1'b0;
			kick_nxt              = 1'b1;
		end
		// Source detection overwrites the limit code
		if (detectDone) begin
			inLim_nxt[4:0] = pselS ? `CIC_ILIM_PSEL_HI
			                       : `CIC_ILIM_PSEL_LO;
		end
		// Host write lands after, so host rewrites win
		if (wrStb) begin
			host_nxt = 1'b1;
			if (ptr_r == `CIC_OFS_INLIM) begin
				inLim_nxt = shift_r;
			end else begin
				ctrl_nxt = shift_r;
			end
		end
		// Expiry restores only watchdog-held fields
		if (watchdogExpired) begin
			inLim_nxt = (inLim_nxt & ~`CIC_WDCLR_INLIM)
			            | (`CIC_RST_INLIM & `CIC_WDCLR_INLIM);
			ctrl_nxt  = (ctrl_nxt & ~`CIC_WDCLR_CTRL0)
			            | (`CIC_RST_CTRL0 & `CIC_WDCLR_CTRL0);
			host_nxt  = 1'b0;
		end
		// Register reset restores every field
		if (regResetCmd) begin
			inLim_nxt = `CIC_RST_INLIM;
			ctrl_nxt  = `CIC_RST_CTRL0;
		end
	end

	// Register group and output registers
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			inLim_r   <= `CIC_RST_INLIM;
			ctrl_r    <= `CIC_RST_CTRL0;
			host_r    <= 1'b0;
			kick_r    <= 1'b0;
			ntcCode_r <= 3'h0;
			useRem_r  <= 1'b0;
			limMa_r   <= 12'h000;
			floorMv_r <= 12'h000;
			bExit_r   <= 12'h000;
			bRise_r   <= 12'h000;
			chgOn_r   <= 1'b0;
			bstOn_r   <= 1'b0;
		end else begin
			inLim_r   <= inLim_nxt;
			ctrl_r    <= ctrl_nxt;
			host_r    <= host_nxt;
			kick_r    <= kick_nxt;
			ntcCode_r <= ctl.ntcCode;
			useRem_r  <= ctl.useRemote;
			limMa_r   <= ctl.limitMa;
			floorMv_r <= ctl.floorMv;
			bExit_r   <= ctl.bstExitMv;
			bRise_r   <= ctl.bstRiseMv;
			chgOn_r   <= ctl.chargeOn;
			bstOn_r   <= ctl.boostOn;
		end
	end

	// Outputs straight from flops, except sdaOut tied low
	assign sdaOut                    = 1'b0;
	assign sdaOe                     = sdaOe_r;
	assign inputDisconnectMode       = inLim_r[`CIC_B_HIZ];
	assign lightLoadPulseSkipDisable = ctrl_r[`CIC_B_PSKIP];
	assign inputCurrentLimitCode     = inLim_r[4:0];
	assign systemFloorVoltageSel     = ctrl_r[3:1];
	assign thermistorFaultCode       = ntcCode_r;
	assign useRemoteSense            = useRem_r;
	assign inputLimitMa              = limMa_r;
	assign systemFloorMv             = floorMv_r;
	assign boostExitMv               = bExit_r;
	assign boostStartMv              = bRise_r;
	assign chargeActive              = chgOn_r;
	assign boostActive               = bstOn_r;
	assign watchdogKick              = kick_r;
	assign hostMode                  = host_r;

endmodule : cic_regs

// ==== hw/cic_map.svh ====
// Purpose: Offsets, field positions, reset values and codes of the
//          charger input-limit and control-zero register pair.
// Assumes: Included by bare name from every design file that needs it.
// Notes:   Operating-point tables are expressed in mA and mV.
// Operation
// - Input-limit register: offset 0x00, reset 0x17
// - Control-zero register: offset 0x01, reset 0x1A
// - Bit 7 high-impedance; cleared by reset, watchdog
// - Bit 6 forces thermistor good, fault 000
// - Bit 5 low uses remote sense unless faulted
// - Limit code: 100 mA plus 100 mA/LSB
// - Detection done loads 500 mA or 2.4 A
// - Control bit 7 disables light-load pulse skip
// - Kick bit restarts watchdog, then self-clears
// - Boost enable; auto switch with charge enable
// - Charge needs pin low, bit, nonzero current
// - Bits 3:1 pick system floor voltage
// - Bit 0 picks boost battery thresholds
// - Host reaches slave address 0x6A over I2C
// - Any host write enters host-controlled mode
`ifndef CIC_MAP_SVH
`define CIC_MAP_SVH

`define CIC_SLAVE_ADDR   7'h6A
`define CIC_OFS_INLIM    8'h00
`define CIC_OFS_CTRL0    8'h01
`define CIC_RST_INLIM    8'h17
`define CIC_RST_CTRL0    8'h1A
`define CIC_WDCLR_INLIM  8'h80
`define CIC_WDCLR_CTRL0  8'h70
`define CIC_READ_FILL    8'hFF

`define CIC_B_HIZ        7
`define CIC_B_TSIGN      6
`define CIC_B_SNSDIS     5
`define CIC_B_PSKIP      7
`define CIC_B_KICK       6
`define CIC_B_BOOST      5
`define CIC_B_CHG        4
`define CIC_B_VBSEL      0

`define CIC_ILIM_PSEL_HI 5'h04
`define CIC_ILIM_PSEL_LO 5'h17
`define CIC_ILIM_STEP_MA 12'h064
`define CIC_NTC_OK       3'h0

`define CIC_FLOOR_0_MV   12'hA28
`define CIC_FLOOR_1_MV   12'hAF0
`define CIC_FLOOR_2_MV   12'hBB8
`define CIC_FLOOR_3_MV   12'hC80
`define CIC_FLOOR_4_MV   12'hD48
`define CIC_FLOOR_5_MV   12'hDAC
`define CIC_FLOOR_6_MV   12'hE10
`define CIC_FLOOR_7_MV   12'hE74
`define CIC_BST_EXIT0_MV 12'hAF0
`define CIC_BST_RISE0_MV 12'hBB8
`define CIC_BST_EXIT1_MV 12'h9C4
`define CIC_BST_RISE1_MV 12'hAF0

`endif

// ==== hw/cic_pkg.sv ====
// Purpose: Types shared by the charger register block.
// Assumes: Constants live in cic_map.svh.
// Notes:   Slave states follow a Gray path along a write transfer.
package cic_pkg;

	// Serial slave states
	typedef enum logic [2:0] {
		ST_IDLE  = 3'h0,
		ST_ADDR  = 3'h1,
		ST_REGA  = 3'h3,
		ST_WDATA = 3'h2,
		ST_RDATA = 3'h6
	} cic_state_t;

endpackage : cic_pkg

// ==== hw/cic_ctl_if.sv ====
// Purpose: Carries register fields and core status to the decoder.
// Assumes: Producer is the register top, consumer the decoder.
// Notes:   Pure wiring, no logic.
interface cic_ctl_if;
	logic [7:0]  inLimReg;        // Input-limit register value
	logic [7:0]  ctrlReg;         // Control-zero register value
	logic        senseFault;      // Remote sense failed
	logic [2:0]  ntcRaw;          // Raw thermistor fault code
	logic        ntcGoodRaw;      // Raw thermistor condition good
	logic        ceLow;           // Charge-enable pin asserted
	logic        adapterOn;       // Adapter attached
	logic        currNonzero;     // Programmed charge current nonzero
	logic        useRemote;       // Regulate through remote sense
	logic        ntcGood;         // Thermistor taken as good
	logic [2:0]  ntcCode;         // Reported thermistor fault code
	logic [11:0] limitMa;         // Input current limit in mA
	logic [11:0] floorMv;         // System floor in mV
	logic [11:0] bstExitMv;       // Boost exit threshold in mV
	logic [11:0] bstRiseMv;       // Boost start threshold in mV
	logic        chargeOn;        // Charging allowed
	logic        boostOn;         // Boost allowed

	modport prod (
		output inLimReg, ctrlReg, senseFault, ntcRaw, ntcGoodRaw,
		       ceLow, adapterOn, currNonzero,
		input  useRemote, ntcGood, ntcCode, limitMa, floorMv,
		       bstExitMv, bstRiseMv, chargeOn, boostOn
	);
	modport dec (
		input  inLimReg, ctrlReg, senseFault, ntcRaw, ntcGoodRaw,
		       ceLow, adapterOn, currNonzero,
		output useRemote, ntcGood, ntcCode, limitMa, floorMv,
		       bstExitMv, bstRiseMv, chargeOn, boostOn
	);
endinterface : cic_ctl_if

// ==== hw/cic_sync.sv ====
// Purpose: Two-flop synchroniser for asynchronous pins.
// Assumes: Each bit is an independent level.
// Notes:   Stage one feeds only stage two.
module cic_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] RSTV = '0
) (
	// Clock and reset
	input  wire logic         clk_sys,
	input  wire logic         nrst,
	// Data
	input  wire logic [W-1:0] din,
	output logic      [W-1:0] dout
);

	// One two-stage chain per bit
	for (genvar i = 0; i < W; i++) begin : g_bit
		logic meta_r;    // First stage, metastable
		logic stab_r;    // Second stage, safe to use
		always_ff @(posedge clk_sys or negedge nrst) begin
			if (!nrst) begin
				meta_r <= RSTV[i];
				stab_r <= RSTV[i];
			end else begin
				meta_r <= din[i];
				stab_r <= meta_r;
			end
		end
		assign dout[i] = stab_r;
	end

endmodule : cic_sync

// ==== hw/cic_decode.sv ====
// Purpose: Turns register fields into operating decisions and values.
// Assumes: Inputs are already in the clk_sys domain.
// Notes:   Purely combinational; the top registers every result except ntcGood.
`include "cic_map.svh"
module cic_decode
	import cic_pkg::*;
(
	// Field and status bundle
	cic_ctl_if.dec ctl
);

	logic ntcGood;    // Thermistor condition after override

	// Thermistor override forces good status and clean code
	always_comb begin
		ntcGood     = ctl.ntcGoodRaw | ctl.inLimReg[`CIC_B_TSIGN];
		ctl.ntcGood = ntcGood;
		ctl.ntcCode = ctl.inLimReg[`CIC_B_TSIGN] ? `CIC_NTC_OK
		                                         : ctl.ntcRaw;
		// Fallback to battery pin when remote sense has failed
		ctl.useRemote = !ctl.inLimReg[`CIC_B_SNSDIS]
		                && !ctl.senseFault;
		// Offset of one step, so code 0 is 100 mA
		ctl.limitMa = (12'(ctl.inLimReg[4:0]) + 12'h001)
		              * `CIC_ILIM_STEP_MA;
		// Charge needs pin, bit and nonzero current together
		ctl.chargeOn = ctl.ceLow && ctl.currNonzero && ntcGood
		               && ctl.ctrlReg[`CIC_B_CHG]
		               && ctl.adapterOn;
		// Boost only while the adapter is absent: with both enables
		// set, attach and removal swap charge and boost by themselves
		ctl.boostOn = ctl.ctrlReg[`CIC_B_BOOST] && !ctl.adapterOn
		              && ntcGood;
		// Boost battery thresholds
		if (ctl.ctrlReg[`CIC_B_VBSEL]) begin
			ctl.bstExitMv = `CIC_BST_EXIT1_MV;
			ctl.bstRiseMv = `CIC_BST_RISE1_MV;
		end else begin
			ctl.bstExitMv = `CIC_BST_EXIT0_MV;
			ctl.bstRiseMv = `CIC_BST_RISE0_MV;
		end
		// System floor table
		case (ctl.ctrlReg[3:1])
			3'h0:    ctl.floorMv = `CIC_FLOOR_0_MV;
			3'h1:    ctl.floorMv = `CIC_FLOOR_1_MV;
			3'h2:    ctl.floorMv = `CIC_FLOOR_2_MV;
			3'h3:    ctl.floorMv = `CIC_FLOOR_3_MV;
			3'h4:    ctl.floorMv = `CIC_FLOOR_4_MV;
			3'h5:    ctl.floorMv = `CIC_FLOOR_5_MV;
			3'h6:    ctl.floorMv = `CIC_FLOOR_6_MV;
			default: ctl.floorMv = `CIC_FLOOR_7_MV;
		endcase
	end

endmodule : cic_decode

// ==== dv/cic_regs_props.sv ====
// Purpose: Port-level checks for the charger register block.
// Assumes: Pins reach the logic through two flops, decodes one more.
// Notes:   Host writes sit away from detection events in the bench.
module cic_regs_props (
	// Clock and reset
	input wire logic        clk_sys,
	input wire logic        nrst,
	// Pins and events
	input wire logic        sclIn,
	input wire logic        regResetCmd,
	input wire logic        watchdogExpired,
	input wire logic        detectDone,
	input wire logic        sourceSelPin,
	input wire logic        chargeEnPin_n,
	input wire logic        chargeCurrentNonzero,
	input wire logic [2:0]  thermistorFaultIn,
	// Outputs under watch
	input wire logic        inputDisconnectMode,
	input wire logic        lightLoadPulseSkipDisable,
	input wire logic [4:0]  inputCurrentLimitCode,
	input wire logic [2:0]  systemFloorVoltageSel,
	input wire logic [2:0]  thermistorFaultCode,
	input wire logic [11:0] inputLimitMa,
	input wire logic [11:0] systemFloorMv,
	input wire logic [11:0] boostExitMv,
	input wire logic [11:0] boostStartMv,
	input wire logic        chargeActive,
	input wire logic        watchdogKick,
	input wire logic        hostMode
);
	logic [11:0] limW; // Code widened for arithmetic
	logic [11:0] selW; // Floor select widened
	assign limW = 12'(inputCurrentLimitCode);
	assign selW = 12'(systemFloorVoltageSel);
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!nrst);
	// First edge after reset still shows reset-time decodes, so skip it
	a_limit_ma_scale: assert property (
		$past(nrst) |-> inputLimitMa == ($past(limW) + 12'h001) * 12'h064)
		else $error("input limit mA mismatch");
	a_floor_table: assert property (
		$past(nrst) |-> systemFloorMv == ($past(selW) < 12'h005 ?
		12'hA28 + 12'h0C8 * $past(selW) : 12'hBB8 + 12'h064 * $past(selW)))
		else $error("floor mV mismatch");
	a_boost_pair: assert property (
		$past(nrst) |-> {boostExitMv, boostStartMv} inside
		{24'hAF_0BB8, 24'h9C_4AF0})
		else $error("boost thresholds not a legal pair");
	a_ntc_code_src: assert property (
		$past(nrst) |-> thermistorFaultCode == 3'h0 ||
		thermistorFaultCode == $past(thermistorFaultIn))
		else $error("thermistor code from nowhere");
	a_kick_one_shot: assert property (
		watchdogKick |=> !watchdogKick)
		else $error("kick longer than one cycle");
	a_expiry_clears: assert property (
		watchdogExpired && !regResetCmd |=> !inputDisconnectMode && !hostMode)
		else $error("expiry left high-impedance or host mode");
	a_regrst_dflt: assert property (
		regResetCmd |=> inputCurrentLimitCode == 5'h17 && !inputDisconnectMode
		&& systemFloorVoltageSel == 3'h5 && !lightLoadPulseSkipDisable)
		else $error("register reset left a field off default");
	// Bus held high for a while means no host write lands this cycle
	a_detect_load: assert property (
		detectDone && !regResetCmd && !watchdogExpired && sclIn &&
		$past(sclIn, 3) |=> inputCurrentLimitCode ==
		($past(sourceSelPin, 3) ? 5'h04 : 5'h17))
		else $error("detection load wrong");
	a_charge_gate: assert property (
		chargeActive |-> !$past(chargeEnPin_n, 3) && $past(chargeCurrentNonzero))
		else $error("charging without pin or current");
endmodule : cic_regs_props

bind cic_regs cic_regs_props u_props (.*);

// ==== dv/cic_host.sv ====
// Purpose: Behavioural I2C master standing in for the host.
// Assumes: SDA is wired-AND with a pull-up in the bench.
// Notes:   SCL phases last 20 clocks, well above the 4 needed.
`include "cic_map.svh"
module cic_host (
	// Clock
	input  wire logic clk_sys,
	// Bus lines
	input  wire logic sdaIn,
	output logic      sclOut,
	output logic      sdaLow
);
	// Bus idle: both lines released
	initial begin
		sclOut = 1'b1;
		sdaLow = 1'b0;
	end
	// Quarter bit, moves only on falling edges
	task automatic q();
		repeat (10) @(negedge clk_sys);
	endtask : q
	// Data changes only while SCL is low
	task automatic bitIo(input logic b, output logic r);
		sdaLow = !b;
		q();
		sclOut = 1'b1;
		q();
		r = sdaIn;
		q();
		sclOut = 1'b0;
		q();
	endtask : bitIo
	// Start or repeated start
	task automatic start();
		sdaLow = 1'b0;
		q();
		sclOut = 1'b1;
		q();
		sdaLow = 1'b1;
		q();
		sclOut = 1'b0;
		q();
	endtask : start
	task automatic stop();
		sdaLow = 1'b1;
		q();
		sclOut = 1'b1;
		q();
		sdaLow = 1'b0;
		q();
	endtask : stop
	// Eight bits MSB first plus the ninth
	task automatic xfer(input logic [8:0] o, output logic [8:0] i);
		for (int k = 8; k >= 0; k--)
			bitIo(o[k], i[k]);
	endtask : xfer
	// Single write; ok is high only if every byte was acknowledged
	task automatic wr(input logic [7:0] a, d, output logic ok);
		logic [8:0] i0, i1, i2;
		start();
		xfer({`CIC_SLAVE_ADDR, 1'b0, 1'b1}, i0);
		xfer({a, 1'b1}, i1);
		xfer({d, 1'b1}, i2);
		stop();
		ok = !(i0[0] | i1[0] | i2[0]);
	endtask : wr
	// Pointer write, repeated start, one byte read, closing NACK
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		logic [8:0] i;
		start();
		xfer({`CIC_SLAVE_ADDR, 1'b0, 1'b1}, i);
		xfer({a, 1'b1}, i);
		start();
		xfer({`CIC_SLAVE_ADDR, 1'b1, 1'b1}, i);
		xfer(9'h1FF, i);
		stop();
		d = i[8:1];
	endtask : rd
endmodule : cic_host

// ==== dv/cic_regs_tb.sv ====
// Purpose: Self-checking bench for the charger register block.
// Assumes: Host model drives SCL/SDA; bench drives pins on falling edges.
// Notes:   Checks queue expectations; a monitor compares in order.
module cic_regs_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_sys, nrst, sclIn, sdaIn, sdaOe, hostLow, ok;
	logic regResetCmd, watchdogExpired, detectDone, sourceSelPin;
	logic chargeEnPin_n, adapterPresentPin, remoteSenseFaultStatus;
	logic thermistorGoodIn, chargeCurrentNonzero, useRemoteSense;
	logic inputDisconnectMode, lightLoadPulseSkipDisable, hostMode;
	logic chargeActive, boostActive, watchdogKick;
	logic [2:0] thermistorFaultIn, thermistorFaultCode, systemFloorVoltageSel;
	logic [4:0] inputCurrentLimitCode;
	logic [11:0] inputLimitMa, systemFloorMv, boostExitMv, boostStartMv;
	logic [11:0] seen, kicks = '0, kExp = '0;
	logic [31:0] r, seed = 32'h0000_0021; // Xorshift state
	logic [7:0] a, b, d;
	int err_total = 0, comparisons = 0;
	string nameQ[$];
	logic [11:0] expQ[$];
	event got;
	// Open drain: pull-up unless someone pulls low
	assign sdaIn = !(sdaOe | hostLow);
	cic_host h (.clk_sys, .sdaIn, .sclOut(sclIn), .sdaLow(hostLow));
	cic_regs DUT (
		.clk_sys, .nrst, .sclIn, .sdaIn, .sdaOut(), .sdaOe, .regResetCmd,
		.watchdogExpired, .detectDone, .sourceSelPin, .chargeEnPin_n,
		.adapterPresentPin, .remoteSenseFaultStatus, .thermistorFaultIn,
		.thermistorGoodIn, .chargeCurrentNonzero, .inputDisconnectMode,
		.lightLoadPulseSkipDisable, .inputCurrentLimitCode,
		.systemFloorVoltageSel, .thermistorFaultCode, .useRemoteSense,
		.inputLimitMa, .systemFloorMv, .boostExitMv, .boostStartMv,
		.chargeActive, .boostActive, .watchdogKick, .hostMode
	);
	initial begin
		clk_sys = 1'b0;
		forever #2 clk_sys = ~clk_sys;
	end
	// Count kick pulses as they leave the block
	always @(posedge clk_sys)
		if (watchdogKick === 1'b1) kicks <= kicks + 12'h001;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction : xs
	// Queue the expectation, hand the observed value to the monitor
	task automatic chk(string n, logic [11:0] s, logic [11:0] e);
		nameQ.push_back(n);
		expQ.push_back(e);
		seen = s;
		->got;
		@(negedge clk_sys);
	endtask : chk
	task automatic pulse(ref logic s);
		s = 1'b1;
		@(negedge clk_sys);
		s = 1'b0;
	endtask : pulse
	task automatic complete_run();
		$display("comparisons %0d err_total %0d", comparisons, err_total);
		if (comparisons > 0 && err_total == 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask : complete_run
	// Monitor takes the oldest note for every result
	initial forever begin
		@got;
		comparisons++;
		if (expQ[0] !== seen) begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nameQ[0], expQ[0], seen);
		end
		void'(nameQ.pop_front());
		void'(expQ.pop_front());
	end
	// 41 transfers of 1.15k to 1.55k clocks; 400 us leaves margin
	initial begin
		#400_000;
		err_total++;
		complete_run();
	end
	initial begin
		nrst = 1'b0;
		{regResetCmd, watchdogExpired, detectDone, sourceSelPin} = 4'h0;
		{chargeEnPin_n, adapterPresentPin, remoteSenseFaultStatus} = 3'h0;
		{thermistorGoodIn, chargeCurrentNonzero} = 2'h3;
		thermistorFaultIn = 3'h0;
		repeat (16) @(negedge clk_sys);
		nrst = 1'b1;
		repeat (4) @(negedge clk_sys);
		h.rd(8'h00, d);
		chk("rd00", 12'(d), 12'h017);
		h.rd(8'h01, d);
		chk("rd01", 12'(d), 12'h01A);
		chk("limMa", inputLimitMa, 12'h960);
		chk("floorMv", systemFloorMv, 12'hDAC);
		chk("host", 12'(hostMode), 12'h000);
		// Each floor code; random fields; pins vary per pass
		for (int i = 0; i < 8; i++) begin
			r = xs();
			a = r[15:8];
			b = {r[7], r[6] | i[0], i[2], ~i[0], i[2:0], r[0]};
			chargeEnPin_n = i[0];
			adapterPresentPin = i[1];
			thermistorFaultIn = r[18:16];
			remoteSenseFaultStatus = r[19];
			kExp += 12'(b[6]);
			h.wr(8'h00, a, ok);
			chk("ack", 12'(ok), 12'h001);
			h.wr(8'h01, b, ok);
			chk("host", 12'(hostMode), 12'h001);
			chk("lim", 12'(inputCurrentLimitCode), 12'(a[4:0]));
			chk("limMa", inputLimitMa, 12'h064 * (12'(a[4:0]) + 1));
			chk("hiz", 12'(inputDisconnectMode), 12'(a[7]));
			chk("pskip", 12'(lightLoadPulseSkipDisable), 12'(b[7]));
			chk("sel", 12'(systemFloorVoltageSel), 12'(i));
			chk("floorMv", systemFloorMv, i < 5 ? 12'hA28 + 12'h0C8 * 12'(i)
				: 12'hBB8 + 12'h064 * 12'(i));
			chk("bExit", boostExitMv, b[0] ? 12'h9C4 : 12'hAF0);
			chk("bStart", boostStartMv, b[0] ? 12'hAF0 : 12'hBB8);
			chk("ntc", 12'(thermistorFaultCode), a[6] ? 0 : r[18:16]);
			chk("remote", 12'(useRemoteSense), 12'(!a[5] && !r[19]));
			chk("chg", 12'(chargeActive), 12'(!i[0] && i[1]));
			chk("bst", 12'(boostActive), 12'(i[2] && !i[1]));
			h.rd(8'h00, d);
			chk("rd00", 12'(d), 12'(a));
			h.rd(8'h01, d);
			chk("rd01", 12'(d), 12'(b & 8'hBF));
		end
		chk("kicks", kicks, kExp);
		// Expiry clears only its own fields
		h.wr(8'h00, 8'hA5, ok);
		h.wr(8'h01, 8'h2F, ok);
		pulse(watchdogExpired);
		chk("host", 12'(hostMode), 12'h000);
		h.rd(8'h00, d);
		chk("rd00", 12'(d), 12'h025);
		h.rd(8'h01, d);
		chk("rd01", 12'(d), 12'h01F);
		pulse(regResetCmd);
		h.rd(8'h00, d);
		chk("rd00", 12'(d), 12'h017);
		h.rd(8'h01, d);
		chk("rd01", 12'(d), 12'h01A);
		// Detection with source select high, then low
		sourceSelPin = 1'b1;
		repeat (4) @(negedge clk_sys);
		pulse(detectDone);
		chk("lim", 12'(inputCurrentLimitCode), 12'h004);
		chk("limMa", inputLimitMa, 12'h1F4);
		sourceSelPin = 1'b0;
		repeat (4) @(negedge clk_sys);
		pulse(detectDone);
		chk("lim", 12'(inputCurrentLimitCode), 12'h017);
		// Unmapped offset is refused
		h.wr(8'h02, 8'h55, ok);
		chk("nack", 12'(ok), 12'h000);
		complete_run();
	end
endmodule : cic_regs_tb
